// [rtl/cks_pkg.sv]
// Shared constants, fuse codes, states and carrier types for clock control
package cks_pkg;

  // Fuse field layout; a fuse bit reads 1 unprogrammed, 0 programmed
  localparam int           SEL_W          = 4;
  localparam int           STSEL_W        = 2;
  localparam int           CNT_W          = 17;
  localparam logic         FUSE_PROGRAMMED = 1'b0;

  // Clock source select codes
  localparam logic [3:0]   SEL_XTAL_LO    = 4'h8;
  localparam logic [3:0]   SEL_LF_FAST    = 4'h6;
  localparam logic [3:0]   SEL_LF_SLOW    = 4'h7;
  localparam logic [3:0]   SEL_RC         = 4'h2;
  localparam logic [3:0]   SEL_EXT        = 4'h0;

  // Start-up time select codes
  localparam logic [1:0]   STSEL_00       = 2'h0;
  localparam logic [1:0]   STSEL_01       = 2'h1;
  localparam logic [1:0]   STSEL_10       = 2'h2;

  // Start-up counts in cycles of the selected source
  localparam logic [16:0]  CK_258         = 17'h00102;
  localparam logic [16:0]  CK_1K          = 17'h00400;
  localparam logic [16:0]  CK_RESET_ADD   = 17'h0000E;
  localparam logic [16:0]  CK_RC_START    = 17'h00006;

  // Reset time-out counts in watchdog oscillator cycles
  localparam logic [16:0]  WDT_NONE       = 17'h00000;
  localparam logic [16:0]  WDT_SHORT      = 17'h01000;

  // Prescale factors
  localparam logic [3:0]   PRESCALE_DIV8  = 4'h8;
  localparam logic [3:0]   PRESCALE_DIV1  = 4'h1;

  // Pin count through the synchroniser
  localparam int           SYNC_PINS      = 6;

  typedef struct packed {
    logic [3:0] clock_source_select;
    logic [1:0] startup_time_select;
    logic       divide_by_eight_fuse;
  } cks_fuse_s;

  // Factory configuration: RC source, longest start-up, divide by 8 programmed
  localparam cks_fuse_s    FUSE_DEFAULT   = '{4'h2, 2'h2, 1'b0};

  typedef struct packed {
    logic core_clock;
    logic peripheral_clock;
    logic program_memory_clock;
    logic async_timer_clock;
    logic converter_clock;
  } cks_gate_s;

  localparam cks_gate_s    GATE_ALL_OFF   = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic xtal;
    logic lowfreq;
    logic rc;
    logic ext;
  } cks_osc_s;

  localparam cks_osc_s     OSC_ALL_OFF    = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef enum logic [2:0] {
    SLP_IDLE       = 3'h0,
    SLP_CONV_NOISE = 3'h1,
    SLP_POWER_DOWN = 3'h2,
    SLP_POWER_SAVE = 3'h3,
    SLP_STANDBY    = 3'h6
  } cks_sleep_e;

  // Gray codes along capture -> reset delay -> run -> sleep -> wake
  typedef enum logic [2:0] {
    ST_CAPTURE = 3'h0,
    ST_POR     = 3'h1,
    ST_RUN     = 3'h3,
    ST_SLEEP   = 3'h2,
    ST_WAKE    = 3'h6,
    ST_INVALID = 3'h4
  } cks_state_e;

endpackage

// [rtl/cks_sync.sv]
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module cks_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pin;
      level  <= stage1;
    end
  end

endmodule

// [rtl/cks_tick_counter.sv]
// Counts tick pulses from load until a target is reached
`timescale 1ns/1ps
module cks_tick_counter (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Control
  input  wire logic        load,
  input  wire logic [16:0] target,
  input  wire logic        tick,
  // Status
  output logic             done
);
  import cks_pkg::*;

  logic [16:0] count;
  logic [16:0] target_q;

  // Finished once the count has reached the loaded target
  assign done = (count >= target_q);

  // Load clears the count; ticks advance it until done
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count    <= '0;
      target_q <= '0;
    end else if (load) begin
      count    <= '0;
      target_q <= target;
    end else if (tick && !done) begin
      count    <= count + 17'h00001;
    end
  end

endmodule

// [rtl/cks_clock_control.sv]
// Clock source selection, start-up timing and clock domain gating
`timescale 1ns/1ps

module cks_clock_control #(
  parameter int P_WDT_LONG   = 65536,
  parameter int P_XTAL_LONG  = 16384,
  parameter int P_LF_LONG    = 32768
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Non-volatile configuration, sampled once after reset
  input  wire logic               fuse_loaded,
  input  wire cks_pkg::cks_fuse_s fuse,
  // Oscillator and watchdog tick pins (asynchronous)
  input  wire logic               xtal_tick,
  input  wire logic               lowfreq_tick,
  input  wire logic               rc_tick,
  input  wire logic               ext_tick,
  input  wire logic               watchdog_oscillator,
  // Sleep control from the core and wake pin
  input  wire logic               sleep_request,
  input  wire cks_pkg::cks_sleep_e sleep_mode,
  input  wire logic               wake_event,
  // Module usage
  input  wire logic               async_timer_enable,
  input  wire logic               converter_enable,
  // Clock domain gates and source enables
  output cks_pkg::cks_gate_s      gate,
  output cks_pkg::cks_osc_s       osc_enable,
  // Status
  output logic                    execute_enable,
  output logic                    async_irq_detect,
  output logic                    serial_start_async,
  output logic [3:0]              prescale_factor,
  output logic                    config_invalid,
  output cks_pkg::cks_state_e     state
);
  import cks_pkg::*;

  cks_fuse_s  cfg;
  cks_fuse_s  cfg_src;
  cks_state_e next_state;
  cks_sleep_e mode_q;
  cks_sleep_e mode_now;
  cks_gate_s  next_gate;
  cks_osc_s   next_osc;
  logic [5:0] pins_sync;
  logic [5:0] pins_prev;
  logic [5:0] pins_rise;
  logic       src_tick;
  logic       wdt_tick;
  logic       wake_sync;
  logic       src_done;
  logic       wdt_done;
  logic       load_src;
  logic       load_wdt;
  logic [16:0] src_target;
  logic       deep_sleep;
  logic       is_xtal;
  logic       is_lf;
  logic       is_rc;
  logic       is_ext;
  logic       is_valid;

  // Start-up cycles on the selected source after power-down or power-save
  function automatic logic [16:0] startup_ck(input cks_fuse_s c);
    logic [16:0] r;
    r = CK_RC_START;
    if (c.clock_source_select >= SEL_XTAL_LO) begin
      if (c.clock_source_select[0] == 1'b0) begin
        r = (c.startup_time_select[1] == 1'b0) ? CK_258 : CK_1K;
      end else begin
        r = (c.startup_time_select == STSEL_00) ? CK_1K
                                                 : 17'(P_XTAL_LONG);
      end
    end else if (c.clock_source_select == SEL_LF_SLOW) begin
      r = 17'(P_LF_LONG);
    end else if (c.clock_source_select == SEL_LF_FAST) begin
      r = CK_1K;
    end
    return r;
  endfunction

  // Watchdog cycles of the reset time-out for this configuration
  function automatic logic [16:0] reset_wdt(input cks_fuse_s c);
    logic [16:0] r;
    logic [2:0]  idx;
    idx = {c.clock_source_select[0], c.startup_time_select};
    r   = 17'(P_WDT_LONG);
    if (c.clock_source_select >= SEL_XTAL_LO) begin
      case (idx)
        3'h0, 3'h3, 3'h6: r = WDT_SHORT;
        3'h2, 3'h5:       r = WDT_NONE;
        default:          r = 17'(P_WDT_LONG);
      endcase
    end else begin
      case (c.startup_time_select)
        STSEL_00: r = WDT_NONE;
        STSEL_01: r = WDT_SHORT;
        STSEL_10: r = 17'(P_WDT_LONG);
        default: r = 17'(P_WDT_LONG);
      endcase
    end
    return r;
  endfunction

  // Pins cross into the clock domain before any logic sees them
  cks_sync #(
    .WIDTH (SYNC_PINS)
  ) u_sync (
    .clk   (clk),
    .rstn  (rstn),
    .pin   ({wake_event, watchdog_oscillator, ext_tick, rc_tick,
             lowfreq_tick, xtal_tick}),
    .level (pins_sync)
  );

  // Rising edges of the synchronised oscillator levels count as ticks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins_sync;
    end
  end

  assign pins_rise = pins_sync & ~pins_prev;
  assign wdt_tick  = pins_rise[4];
  assign wake_sync = pins_sync[5];

  // Capture decodes the incoming fuses at once, so a reserved code can
  // never start the counters; entry gating uses the mode being requested
  assign cfg_src  = (state != ST_CAPTURE) ? cfg
                  : (fuse_loaded ? fuse : FUSE_DEFAULT);
  assign mode_now = (state == ST_RUN) ? sleep_mode : mode_q;
  assign is_xtal  = (cfg_src.clock_source_select >= SEL_XTAL_LO);
  assign is_lf    = (cfg_src.clock_source_select == SEL_LF_FAST) ||
                    (cfg_src.clock_source_select == SEL_LF_SLOW);
  assign is_rc    = (cfg_src.clock_source_select == SEL_RC);
  assign is_ext   = (cfg_src.clock_source_select == SEL_EXT);
  assign is_valid = is_xtal | is_lf | is_rc | is_ext;

  // Ticks of the selected source; none when the code is reserved
  assign src_tick = (is_xtal & pins_rise[0]) | (is_lf & pins_rise[1]) |
                    (is_rc & pins_rise[2]) | (is_ext & pins_rise[3]);

  assign deep_sleep = (mode_now == SLP_POWER_DOWN) ||
                      (mode_now == SLP_POWER_SAVE);

  // both counters start together at reset
  assign load_wdt = (state == ST_CAPTURE) && is_valid;
  assign load_src = load_wdt ||
                    ((state == ST_SLEEP) && wake_sync && deep_sleep);
  // Reset adds the fixed 14 source clocks to the start-up count
  assign src_target = startup_ck(cfg_src) +
                      ((state == ST_CAPTURE) ? CK_RESET_ADD : 17'h00000);

  cks_tick_counter u_src_count (
    .clk    (clk),
    .rstn   (rstn),
    .load   (load_src),
    .target (src_target),
    .tick   (src_tick),
    .done   (src_done)
  );

  cks_tick_counter u_wdt_count (
    .clk    (clk),
    .rstn   (rstn),
    .load   (load_wdt),
    .target (reset_wdt(cfg_src)),
    .tick   (wdt_tick),
    .done   (wdt_done)
  );

  // factory defaults until fuses are captured
  // fuse values taken as read, programmed bits are zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= FUSE_DEFAULT;
    end else if (state == ST_CAPTURE) begin
      cfg <= cfg_src;
    end
  end

  // Sleep mode is held for the whole sleep period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= SLP_IDLE;
    end else if (state == ST_RUN && sleep_request) begin
      mode_q <= sleep_mode;
    end
  end

  // Sequencer; capture lasts one cycle and decodes the fuses directly
  always_comb begin
    next_state = state;
    case (state)
      ST_CAPTURE: begin
        next_state = is_valid ? ST_POR : ST_INVALID;
      end
      ST_POR: begin
        if (src_done && wdt_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_request) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_sync) begin
          next_state = deep_sleep ? ST_WAKE : ST_RUN;
        end
      end
      // execution waits for the start-up count
      ST_WAKE: begin
        if (src_done) begin
          next_state = ST_RUN;
        end
      end
      // stay halted on a reserved code
      ST_INVALID: begin
        next_state = ST_INVALID;
      end
      default: begin
        next_state = ST_CAPTURE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_CAPTURE;
    end else begin
      state <= next_state;
    end
  end

  // Domain gates per state and sleep mode
  always_comb begin
    next_gate = GATE_ALL_OFF;
    if (next_state == ST_RUN) begin
      next_gate.core_clock       = 1'b1;
      next_gate.peripheral_clock = 1'b1;
      next_gate.converter_clock  = converter_enable;
    end else if (next_state == ST_SLEEP) begin
      // sleep mode decides which domains stop
      case (mode_now)
        SLP_IDLE: begin
          next_gate.peripheral_clock = 1'b1;
          next_gate.converter_clock  = converter_enable;
        end
        // converter keeps running while core and peripherals halt
        SLP_CONV_NOISE: begin
          next_gate.converter_clock  = converter_enable;
        end
        default: begin
          next_gate.converter_clock  = 1'b0;
        end
      endcase
    end
    // program memory follows the core clock
    next_gate.program_memory_clock = next_gate.core_clock;
    // async timer runs in every state but capture, invalid and power-down sleep
    next_gate.async_timer_clock = async_timer_enable && is_valid &&
      (next_state != ST_CAPTURE) && (next_state != ST_INVALID) &&
      !(next_state == ST_SLEEP && mode_now == SLP_POWER_DOWN);
  end

  // Oscillator enables; deep sleep stops the source except a watch crystal feeding the async timer in power-save; standby keeps it
  always_comb begin
    next_osc = OSC_ALL_OFF;
    if (next_state != ST_INVALID && next_state != ST_CAPTURE &&
        !(next_state == ST_SLEEP && deep_sleep)) begin
      next_osc.xtal    = is_xtal;
      next_osc.lowfreq = is_lf;
      next_osc.rc      = is_rc;
      next_osc.ext     = is_ext;
    end
    // The watch crystal also feeds the async timer in power-save
    if (next_state == ST_SLEEP && mode_now == SLP_POWER_SAVE && is_lf) begin
      next_osc.lowfreq = async_timer_enable;
    end
  end

  // Registered outputs; only the source enable and async timer gate are on until the delays end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate           <= GATE_ALL_OFF;
      osc_enable     <= OSC_ALL_OFF;
      config_invalid <= 1'b0;
    end else begin
      gate           <= next_gate;
      osc_enable     <= next_osc;
      config_invalid <= (next_state == ST_INVALID);
    end
  end

  // Core runs only with its clock enabled
  assign execute_enable = gate.core_clock;

  // async interrupt detect while peripheral clock halted
  assign async_irq_detect = !gate.peripheral_clock;
  // serial start detection goes asynchronous when halted
  assign serial_start_async     = !gate.peripheral_clock;

  // prescale by 8 when the divide fuse is programmed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prescale_factor <= PRESCALE_DIV8;
    end else if (state == ST_CAPTURE) begin
      prescale_factor <= (cfg_src.divide_by_eight_fuse == FUSE_PROGRAMMED)
                       ? PRESCALE_DIV8 : PRESCALE_DIV1;
    end
  end

endmodule

// [verification/cks_clock_control_props.sv]
// Concurrent checks on the clock control block ports
`timescale 1ns/1ps
module cks_clock_control_props
  import cks_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                rstn,
  // Configuration and sleep inputs
  input wire logic                fuse_loaded,
  input wire cks_pkg::cks_fuse_s  fuse,
  input wire logic                sleep_request,
  input wire logic                async_timer_enable,
  input wire logic                converter_enable,
  // Outputs under watch
  input wire cks_pkg::cks_gate_s  gate,
  input wire cks_pkg::cks_osc_s   osc_enable,
  input wire logic                execute_enable,
  input wire logic                async_irq_detect,
  input wire logic                serial_start_async,
  input wire logic [3:0]          prescale_factor,
  input wire logic                config_invalid,
  input wire cks_pkg::cks_state_e state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Sleep entry and deep wake are two-step behaviours
  sequence s_sleep_req;
    state == ST_RUN && sleep_request;
  endsequence
  sequence s_enter_wake;
    state == ST_SLEEP ##1 state == ST_WAKE;
  endsequence

  a_exec_core_tie: assert property (execute_enable == gate.core_clock)
    else $error("execute enable differs from core gate");
  a_async_irq_mode: assert property (
    async_irq_detect == !gate.peripheral_clock)
    else $error("async interrupt detect wrong");
  a_serial_start_async: assert property (
    serial_start_async == !gate.peripheral_clock)
    else $error("serial start detect wrong");
  a_flash_with_core: assert property (
    gate.program_memory_clock == gate.core_clock)
    else $error("program memory gate differs from core");
  a_invalid_no_osc: assert property (config_invalid |->
    osc_enable == OSC_ALL_OFF && !gate.core_clock)
    else $error("source enabled on reserved code");
  a_core_needs_run: assert property (
    gate.core_clock |-> state == ST_RUN)
    else $error("core clock outside run state");
  a_capture_leaves: assert property (rstn && state == ST_CAPTURE |=>
    state inside {ST_POR, ST_INVALID})
    else $error("capture state held too long");
  a_sleep_entry: assert property (s_sleep_req |=>
    state == ST_SLEEP && !gate.core_clock)
    else $error("sleep entry did not gate core");
  a_async_timer_en: assert property (
    gate.async_timer_clock |-> $past(async_timer_enable))
    else $error("async timer clock without enable");
  a_conv_needs_en: assert property (
    gate.converter_clock |-> $past(converter_enable))
    else $error("converter clock without enable");
  a_prescale_fuse: assert property (state != ST_CAPTURE |->
    prescale_factor == ((!fuse_loaded ||
    fuse.divide_by_eight_fuse == FUSE_PROGRAMMED) ?
    PRESCALE_DIV8 : PRESCALE_DIV1))
    else $error("prescale factor wrong");
  a_wake_osc_on: assert property (s_enter_wake |-> ##1
    (osc_enable != OSC_ALL_OFF && !execute_enable))
    else $error("wake count without source");
endmodule

bind cks_clock_control cks_clock_control_props u_props (
  .clk(clk), .rstn(rstn), .fuse_loaded(fuse_loaded), .fuse(fuse),
  .sleep_request(sleep_request), .async_timer_enable(async_timer_enable),
  .converter_enable(converter_enable), .gate(gate),
  .osc_enable(osc_enable), .execute_enable(execute_enable),
  .async_irq_detect(async_irq_detect),
  .serial_start_async(serial_start_async),
  .prescale_factor(prescale_factor), .config_invalid(config_invalid),
  .state(state));

// [verification/cks_osc_model.sv]
// Behavioural oscillators and watchdog oscillator feeding the block
`timescale 1ns/1ps
module cks_osc_model
  import cks_pkg::*;
#(
  parameter int HALF_SRC = 4,
  parameter int HALF_WDT = 6
) (
  // Clock and enables
  input  wire logic              clk,
  input  wire cks_pkg::cks_osc_s osc_enable,
  // Oscillator levels
  output logic                   xtal_tick,
  output logic                   lowfreq_tick,
  output logic                   rc_tick,
  output logic                   ext_tick,
  output logic                   watchdog_oscillator
);
  logic [4:0] run;
  logic [4:0] lvl = '0;
  int         cnt [5] = '{0, 0, 0, 0, 0};

  // watchdog runs regardless of the chosen source
  assign run = {osc_enable, 1'b1};
  assign {xtal_tick, lowfreq_tick, rc_tick, ext_tick} = lvl[4:1];
  assign watchdog_oscillator = lvl[0];

  // stopped source stands still low, never stale toggling
  // Levels move by non-blocking update so the first sync stage never races
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (!run[i]) begin
        cnt[i] = 0;
        lvl[i] <= 1'b0;
      end else if (cnt[i] >= ((i == 0) ? HALF_WDT : HALF_SRC) - 1) begin
        cnt[i] = 0;
        lvl[i] <= ~lvl[i];
      end else begin
        cnt[i]++;
      end
    end
  end
endmodule

// [verification/clock_source_select_startup_test.sv]
// Self-checking bench for clock source selection and start-up
`timescale 1ns/1ps
module clock_source_select_startup_test;
  import cks_pkg::*;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       fuse_loaded = 1'b0;
  logic       sleep_request = 1'b0;
  logic       wake_event = 1'b0;
  logic       async_timer_enable = 1'b1;
  logic       converter_enable = 1'b1;
  cks_fuse_s  fuse = '0;
  cks_sleep_e sleep_mode = SLP_IDLE;
  logic       xtal_tick, lowfreq_tick, rc_tick, ext_tick, watchdog_oscillator;
  cks_gate_s  gate;
  cks_osc_s   osc_enable;
  cks_state_e state;
  logic       execute_enable, async_irq_detect, serial_start_async;
  logic       config_invalid;
  logic [3:0] prescale_factor;
  int         err_count = 0;
  int         checked = 0;
  cks_sleep_e modes [5] = '{SLP_IDLE, SLP_CONV_NOISE, SLP_POWER_DOWN,
                            SLP_POWER_SAVE, SLP_STANDBY};
  cks_gate_s  gexp [5] = '{5'h0B, 5'h03, 5'h00, 5'h02, 5'h02};

  // Short counts keep the run brief; expectations scale with them
  cks_clock_control #(
    .P_WDT_LONG(40), .P_XTAL_LONG(30), .P_LF_LONG(30)
  ) u_dut (
    .clk(clk), .rstn(rstn), .fuse_loaded(fuse_loaded), .fuse(fuse),
    .xtal_tick(xtal_tick), .lowfreq_tick(lowfreq_tick), .rc_tick(rc_tick),
    .ext_tick(ext_tick), .watchdog_oscillator(watchdog_oscillator),
    .sleep_request(sleep_request), .sleep_mode(sleep_mode),
    .wake_event(wake_event), .async_timer_enable(async_timer_enable),
    .converter_enable(converter_enable), .gate(gate),
    .osc_enable(osc_enable), .execute_enable(execute_enable),
    .async_irq_detect(async_irq_detect),
    .serial_start_async(serial_start_async),
    .prescale_factor(prescale_factor), .config_invalid(config_invalid),
    .state(state));

  cks_osc_model u_osc (
    .clk(clk), .osc_enable(osc_enable), .xtal_tick(xtal_tick),
    .lowfreq_tick(lowfreq_tick), .rc_tick(rc_tick), .ext_tick(ext_tick),
    .watchdog_oscillator(watchdog_oscillator));

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Reset held 16 cycles with the fuse word applied meanwhile
  task automatic start(input logic ld, input cks_fuse_s f);
    @(posedge clk);
    rstn <= 1'b0;
    fuse_loaded <= ld;
    fuse <= f;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
  endtask

  // Bounded wait for execution to resume
  task automatic wait_run();
    int n;
    n = 0;
    while (execute_enable !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    check(execute_enable, 1'b1);
  endtask

  // Enter one sleep mode, check gating, then wake
  task automatic sleep_wake(input cks_sleep_e m, input cks_gate_s g);
    logic deep;
    deep = (m == SLP_POWER_DOWN || m == SLP_POWER_SAVE);
    @(posedge clk);
    sleep_mode <= m;
    sleep_request <= 1'b1;
    @(posedge clk);
    sleep_request <= 1'b0;
    cyc(1);
    check(state, ST_SLEEP);
    check(gate, g);
    check(osc_enable, deep ? 4'h0 : 4'h2);
    check(serial_start_async, !g.peripheral_clock);
    check(async_irq_detect, !g.peripheral_clock);
    @(posedge clk);
    wake_event <= 1'b1;
    cyc(5);
    if (deep) begin
      check(state, ST_WAKE);
    end
    wait_run();
    @(posedge clk);
    wake_event <= 1'b0;
    cyc(4);
  endtask

  function automatic cks_osc_s oexp(input int c);
    if (c >= 8) return 4'h8;
    if (c == 6 || c == 7) return 4'h4;
    if (c == 2) return 4'h2;
    if (c == 0) return 4'h1;
    return 4'h0;
  endfunction

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected few thousand cycles
  initial begin
    #(20 * 40000);
    err_count++;
    final_report();
  end

  initial begin
    // Factory default: RC, long watchdog delay, divide by 8
    start(1'b0, 7'h7F);
    cyc(3);
    check(osc_enable, 4'h2);
    check(prescale_factor, PRESCALE_DIV8);
    cyc(300);
    check(execute_enable, 1'b0);
    wait_run();
    check(gate, 5'h1F);
    // Unused converter and timer domains stay gated while running
    @(posedge clk);
    converter_enable <= 1'b0;
    async_timer_enable <= 1'b0;
    cyc(2);
    check(gate, 5'h1C);
    @(posedge clk);
    converter_enable <= 1'b1;
    async_timer_enable <= 1'b1;
    cyc(2);
    check(gate, 5'h1F);
    $display("Test default start-up done");
    for (int i = 0; i < 5; i++) begin
      sleep_wake(modes[i], gexp[i]);
    end
    $display("Test sleep modes done");
    // Crystal 16K start-up, no watchdog delay, divider unprogrammed
    start(1'b1, '{4'hF, 2'h1, 1'b1});
    cyc(200);
    check(execute_enable, 1'b0);
    wait_run();
    check(prescale_factor, PRESCALE_DIV1);
    check(osc_enable, 4'h8);
    $display("Test crystal start-up done");
    // Every source code, reserved ones included
    for (int i = 0; i < 16; i++) begin
      start(1'b1, '{i[3:0], 2'h0, 1'b1});
      cyc(3);
      check(config_invalid, i inside {1, 3, 4, 5});
      check(osc_enable, oexp(i));
    end
    $display("Test source codes done");
    final_report();
  end
endmodule
